// File: hw/amp_clock_mute_volume_regs.sv
// Function
// - Bypass clock ratio decoded per rate group
// - Fault pin low mode selects slave address
// - Fault pin high mode drives error output
// - DC blocking high-pass near 1 Hz
// - Control bit 6 bypasses DC blocker
// - Master mute silences both channels
// - Each channel mutes on its own
// - Mute changes fade out or in gradually
// - Control bit 0 enables low-supply compensation
// - Master and two channel gains, +12 to -103
// - Channel gain is master plus channel dB
// - Half-dB codes, 0x18 is 0 dB, top mutes
module amp_clock_mute_volume_regs (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic faultIn,
	output logic faultOut,
	output logic faultOe,
	input wire logic errorIn,
	input wire logic sampleStrobe,
	input wire logic signed [23:0] leftIn,
	input wire logic signed [23:0] rightIn,
	output logic signed [23:0] leftOut,
	output logic signed [23:0] rightOut,
	output logic bclkEnable,
	output logic [1:0] sampleRateGroup,
	output logic [10:0] clkRatio,
	output logic ratioValid,
	output logic uvThresholdSel,
	output logic softResetActive
);
	logic [7:0] clockRate, pinCtrl, masterGain;
	logic [7:0] chanGain [2];
	logic [7:0] next_clockRate, next_pinCtrl, next_masterGain;
	logic [7:0] next_chanGain [2];
	logic [7:0] regAddr, wrData, rdData;
	logic wrEn, addrSel, next_addrSel;
	logic signed [23:0] sampleIn [2];
	logic signed [23:0] prevIn [2], next_prevIn [2];
	logic signed [31:0] hpfState [2], next_hpfState [2];
	logic signed [23:0] prevHpf [2], next_prevHpf [2];
	logic signed [23:0] hpfOut [2], compOut [2], gained [2];
	logic signed [23:0] chanOut [2], next_chanOut [2];
	logic [8:0] fade [2], next_fade [2];
	logic muteReq [2];
	logic audioReset;

	function automatic logic signed [23:0] sat24(input logic signed [47:0] v);
		if (v > 48'sh7F_FFFF)
			return 24'sh7F_FFFF;
		if (v < -48'sh80_0000)
			return -24'sh80_0000;
		return v[23:0];
	endfunction

	// Zero marks a reserved code
	function automatic logic [10:0] ratio_decode(input logic [1:0] grp, input logic [3:0] code);
		case (code)
			4'h0: return (grp == 2'h0) ? 11'h400 : ((grp == 2'h1) ? 11'h200 : 11'h100);
			4'h1: return 11'h040;
			4'h2: return 11'h080;
			4'h3: return 11'h0C0;
			4'h4: return 11'h100;
			4'h5: return grp[1] ? 11'h000 : 11'h180;
			4'h6: return grp[1] ? 11'h000 : 11'h200;
			4'h7: return (grp == 2'h0) ? 11'h240 : 11'h000;
			4'h8: return (grp == 2'h0) ? 11'h300 : 11'h000;
			4'h9: return (grp == 2'h0) ? 11'h400 : 11'h000;
			default: return 11'h000;
		endcase
	endfunction

	// 10^(-k/40) in Q15, one entry per half-dB step
	function automatic logic [15:0] gain_mantissa(input logic [3:0] k);
		case (k)
			4'h0: return 16'h8000;
			4'h1: return 16'h78D7;
			4'h2: return 16'h7215;
			4'h3: return 16'h6BB3;
			4'h4: return 16'h65AD;
			4'h5: return 16'h5FFD;
			4'h6: return 16'h5A9E;
			4'h7: return 16'h558C;
			4'h8: return 16'h50C3;
			4'h9: return 16'h4C3F;
			4'hA: return 16'h47FB;
			default: return 16'h43F4;
		endcase
	endfunction

	function automatic logic signed [23:0] apply_gain(input logic signed [23:0] s,
			input logic [7:0] a, input logic [7:0] b);
		logic [8:0] total;
		logic [5:0] octaves;
		logic [3:0] step;
		logic signed [47:0] p;
		total = {1'b0, a} + {1'b0, b};
		octaves = 6'(total / amp_regs_pkg::CODES_PER_OCTAVE);
		step = 4'(total % amp_regs_pkg::CODES_PER_OCTAVE);
		p = 48'(s) * $signed({32'h0000_0000, gain_mantissa(step)});
		p = p >>> (6'(amp_regs_pkg::GAIN_BASE_SHIFT) + octaves);
		if (a >= amp_regs_pkg::GAIN_MUTE_CODE || b >= amp_regs_pkg::GAIN_MUTE_CODE)
			return 24'sh00_0000;
		return sat24(p);
	endfunction

	i2c_reg_port port (
		.sys_clk(sys_clk),
		.rst(rst),
		.sclIn(sclIn),
		.sdaIn(sdaIn),
		.devAddr({amp_regs_pkg::DEV_ADDR_BASE, addrSel}),
		.rdData(rdData),
		.regAddr(regAddr),
		.wrEn(wrEn),
		.wrData(wrData),
		.sdaOe(sdaOe)
	);

	always_comb begin
		if (regAddr == amp_regs_pkg::REG_CLOCK_RATE)
			rdData = clockRate;
		else if (regAddr == amp_regs_pkg::REG_PIN_FILTER_MUTE)
			rdData = pinCtrl;
		else if (regAddr == amp_regs_pkg::REG_MASTER_GAIN)
			rdData = masterGain;
		else if (regAddr == amp_regs_pkg::REG_LEFT_GAIN)
			rdData = chanGain[0];
		else if (regAddr == amp_regs_pkg::REG_RIGHT_GAIN)
			rdData = chanGain[1];
		else
			rdData = 8'h00;
	end

	always_comb begin
		next_clockRate = clockRate;
		next_pinCtrl = pinCtrl;
		next_masterGain = masterGain;
		next_chanGain = chanGain;
		// Pin is only an address strap while in input mode
		next_addrSel = pinCtrl[amp_regs_pkg::BIT_FAULT_MODE] ? addrSel : faultIn;
		if (wrEn) begin
			if (regAddr == amp_regs_pkg::REG_CLOCK_RATE)
				next_clockRate = wrData;
			else if (regAddr == amp_regs_pkg::REG_PIN_FILTER_MUTE)
				next_pinCtrl = wrData;
			else if (regAddr == amp_regs_pkg::REG_MASTER_GAIN)
				next_masterGain = wrData;
			else if (regAddr == amp_regs_pkg::REG_LEFT_GAIN)
				next_chanGain[0] = wrData;
			else if (regAddr == amp_regs_pkg::REG_RIGHT_GAIN)
				next_chanGain[1] = wrData;
		end
	end

	assign audioReset = ~pinCtrl[amp_regs_pkg::BIT_SOFT_RST_N];
	assign sampleIn[0] = leftIn;
	assign sampleIn[1] = rightIn;
	assign muteReq[0] = pinCtrl[amp_regs_pkg::BIT_MASTER_MUTE] | pinCtrl[amp_regs_pkg::BIT_LEFT_MUTE];
	assign muteReq[1] = pinCtrl[amp_regs_pkg::BIT_MASTER_MUTE] | pinCtrl[amp_regs_pkg::BIT_RIGHT_MUTE];

	always_comb begin
		int k;
		k = amp_regs_pkg::HPF_SHIFT_LOW;
		if (clockRate[amp_regs_pkg::FS_LSB +: 2] == 2'h1)
			k = amp_regs_pkg::HPF_SHIFT_MID;
		else if (clockRate[amp_regs_pkg::FS_LSB + 1])
			k = amp_regs_pkg::HPF_SHIFT_HIGH;
		for (int c = 0; c < 2; c++) begin
			next_prevIn[c] = prevIn[c];
			next_hpfState[c] = hpfState[c];
			next_prevHpf[c] = prevHpf[c];
			next_fade[c] = fade[c];
			next_chanOut[c] = chanOut[c];
			// First-order DC blocker: y = x - x1 + y1 - y1*2^-k
			next_hpfState[c] = 32'(sampleIn[c]) - 32'(prevIn[c]) + hpfState[c]
				- (hpfState[c] >>> k);
			hpfOut[c] = sat24(48'(next_hpfState[c]));
			if (pinCtrl[amp_regs_pkg::BIT_DC_BYPASS])
				hpfOut[c] = sampleIn[c];
			// Gentle treble cut offsets the lift seen on a low supply
			compOut[c] = hpfOut[c];
			if (pinCtrl[amp_regs_pkg::BIT_COMP_EN])
				compOut[c] = 24'((26'(hpfOut[c]) * 26'sd3 + 26'(prevHpf[c])) >>> 2);
			gained[c] = apply_gain(compOut[c], masterGain, chanGain[c]);
			if (sampleStrobe) begin
				next_prevIn[c] = sampleIn[c];
				next_prevHpf[c] = hpfOut[c];
				next_chanOut[c] = sat24((48'(gained[c]) * $signed({39'h0, fade[c]}))
					>>> amp_regs_pkg::FADE_SHIFT);
				// One step per sample; only soft reset drops the fade straight to zero
				if (muteReq[c] && fade[c] != 9'h000)
					next_fade[c] = fade[c] - 9'h001;
				else if (!muteReq[c] && fade[c] != amp_regs_pkg::FADE_FULL)
					next_fade[c] = fade[c] + 9'h001;
			end
			if (!sampleStrobe)
				next_hpfState[c] = hpfState[c];
			if (audioReset) begin
				next_prevIn[c] = 24'sh00_0000;
				next_hpfState[c] = 32'sh0000_0000;
				next_prevHpf[c] = 24'sh00_0000;
				next_fade[c] = 9'h000;
				next_chanOut[c] = 24'sh00_0000;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			clockRate <= amp_regs_pkg::CLOCK_RATE_RST;
			pinCtrl <= amp_regs_pkg::PIN_FILTER_MUTE_RST;
			masterGain <= amp_regs_pkg::GAIN_RST;
			chanGain[0] <= amp_regs_pkg::GAIN_RST;
			chanGain[1] <= amp_regs_pkg::GAIN_RST;
			addrSel <= 1'b0;
			for (int c = 0; c < 2; c++) begin
				prevIn[c] <= 24'sh00_0000;
				hpfState[c] <= 32'sh0000_0000;
				prevHpf[c] <= 24'sh00_0000;
				fade[c] <= 9'h000;
				chanOut[c] <= 24'sh00_0000;
			end
			leftOut <= 24'sh00_0000;
			rightOut <= 24'sh00_0000;
			sdaOut <= 1'b0;
			faultOut <= 1'b0;
			faultOe <= 1'b0;
			bclkEnable <= 1'b0;
			sampleRateGroup <= 2'h0;
			clkRatio <= 11'h000;
			ratioValid <= 1'b0;
			uvThresholdSel <= 1'b0;
			softResetActive <= 1'b0;
		end else begin
			clockRate <= next_clockRate;
			pinCtrl <= next_pinCtrl;
			masterGain <= next_masterGain;
			chanGain <= next_chanGain;
			addrSel <= next_addrSel;
			prevIn <= next_prevIn;
			hpfState <= next_hpfState;
			prevHpf <= next_prevHpf;
			fade <= next_fade;
			chanOut <= next_chanOut;
			leftOut <= next_chanOut[0];
			rightOut <= next_chanOut[1];
			sdaOut <= 1'b0;
			faultOut <= 1'b0;
			// Open-drain, active-low error line
			faultOe <= pinCtrl[amp_regs_pkg::BIT_FAULT_MODE] & errorIn;
			bclkEnable <= clockRate[amp_regs_pkg::BIT_BCLK_EN];
			sampleRateGroup <= clockRate[amp_regs_pkg::FS_LSB +: 2];
			clkRatio <= ratio_decode(clockRate[amp_regs_pkg::FS_LSB +: 2],
				clockRate[amp_regs_pkg::RATIO_LSB +: 4]);
			ratioValid <= ratio_decode(clockRate[amp_regs_pkg::FS_LSB +: 2],
				clockRate[amp_regs_pkg::RATIO_LSB +: 4]) != 11'h000;
			uvThresholdSel <= pinCtrl[amp_regs_pkg::BIT_UV_SEL];
			softResetActive <= audioReset;
		end
	end

	ratio_low_a: assert property (@(posedge sys_clk) disable iff (rst)
		(clockRate[5:0] == 6'h00) |=> (clkRatio == 11'h400 && ratioValid))
		else $error("ratio code 0 in low group is not 1024x");
	fault_input_a: assert property (@(posedge sys_clk) disable iff (rst)
		!pinCtrl[amp_regs_pkg::BIT_FAULT_MODE] |=> !faultOe && addrSel == $past(faultIn))
		else $error("fault pin driven or address not sampled in input mode");
	fault_output_a: assert property (@(posedge sys_clk) disable iff (rst)
		(pinCtrl[amp_regs_pkg::BIT_FAULT_MODE] && errorIn) |=> faultOe)
		else $error("error not driven on fault pin");
	dc_bypass_a: assert property (@(posedge sys_clk) disable iff (rst)
		(sampleStrobe && !audioReset && pinCtrl[6] && !pinCtrl[0]) |=> prevHpf[0] == $past(leftIn))
		else $error("DC blocker not bypassed");
	master_mute_a: assert property (@(posedge sys_clk) disable iff (rst)
		(pinCtrl[amp_regs_pkg::BIT_MASTER_MUTE] && fade[1] == 9'h000) |=> fade[1] == 9'h000)
		else $error("right channel rises under master mute");
	chan_independent_a: assert property (@(posedge sys_clk) disable iff (rst)
		(pinCtrl[4:1] == 4'b1010 && sampleStrobe)
		|=> fade[1] == (($past(fade[1]) == amp_regs_pkg::FADE_FULL) ?
			amp_regs_pkg::FADE_FULL : $past(fade[1]) + 9'h001))
		else $error("left mute disturbed right fade");
	fade_out_a: assert property (@(posedge sys_clk) disable iff (rst)
		(muteReq[0] && !audioReset && sampleStrobe && fade[0] != 9'h000)
		|=> fade[0] == $past(fade[0]) - 9'h001)
		else $error("fade-out did not step down by one");
	mute_code_a: assert property (@(posedge sys_clk) disable iff (rst)
		((masterGain >= amp_regs_pkg::GAIN_MUTE_CODE || chanGain[1] >= amp_regs_pkg::GAIN_MUTE_CODE)
		&& sampleStrobe) |=> chanOut[1] == 24'sh00_0000 ##1 rightOut == 24'sh00_0000)
		else $error("mute gain code passed signal");
endmodule

// File: hw/amp_regs_pkg.sv
package amp_regs_pkg;
	// Register offsets
	localparam logic [7:0] REG_CLOCK_RATE = 8'h01;
	localparam logic [7:0] REG_PIN_FILTER_MUTE = 8'h02;
	localparam logic [7:0] REG_MASTER_GAIN = 8'h03;
	localparam logic [7:0] REG_LEFT_GAIN = 8'h04;
	localparam logic [7:0] REG_RIGHT_GAIN = 8'h05;
	// Values after reset
	localparam logic [7:0] CLOCK_RATE_RST = 8'h01;
	localparam logic [7:0] PIN_FILTER_MUTE_RST = 8'h10;
	localparam logic [7:0] GAIN_RST = 8'h18;
	// Field positions, clock_rate_control
	localparam int BIT_BCLK_EN = 7;
	localparam int FS_LSB = 4;
	localparam int RATIO_LSB = 0;
	// Field positions, pin_filter_mute_control
	localparam int BIT_FAULT_MODE = 7;
	localparam int BIT_DC_BYPASS = 6;
	localparam int BIT_UV_SEL = 5;
	localparam int BIT_SOFT_RST_N = 4;
	localparam int BIT_MASTER_MUTE = 3;
	localparam int BIT_LEFT_MUTE = 2;
	localparam int BIT_RIGHT_MUTE = 1;
	localparam int BIT_COMP_EN = 0;
	// Gain codes: 0.5 dB per code, twelve codes per factor of two
	localparam logic [7:0] GAIN_MUTE_CODE = 8'hE7;
	localparam logic [8:0] CODES_PER_OCTAVE = 9'h00C;
	localparam int GAIN_BASE_SHIFT = 11;
	// Fade ramp, one step per sample
	localparam logic [8:0] FADE_FULL = 9'h100;
	localparam int FADE_SHIFT = 8;
	// DC blocker coefficient shifts, roughly 1 Hz per rate group
	localparam int HPF_SHIFT_LOW = 13;
	localparam int HPF_SHIFT_MID = 14;
	localparam int HPF_SHIFT_HIGH = 15;
	// Upper six bits of the slave address; arbitrary value
	localparam logic [5:0] DEV_ADDR_BASE = 6'h0C;
	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_DEV = 4'h1,
		S_DEVACK = 4'h3,
		S_PTR = 4'h2,
		S_PTRACK = 4'h6,
		S_WR = 4'h7,
		S_WRACK = 4'h5,
		S_RD = 4'h4,
		S_RDACK = 4'hC
	} i2c_state_e;
endpackage

// File: hw/i2c_reg_port.sv
module i2c_reg_port (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic sclIn,
	input wire logic sdaIn,
	input wire logic [6:0] devAddr,
	input wire logic [7:0] rdData,
	output logic [7:0] regAddr,
	output logic wrEn,
	output logic [7:0] wrData,
	output logic sdaOe
);
	amp_regs_pkg::i2c_state_e state, next_state;
	logic [3:0] bitCnt, next_bitCnt;
	logic [7:0] shiftReg, next_shiftReg;
	logic [7:0] next_regAddr, next_wrData;
	logic isRead, next_isRead;
	logic next_wrEn, next_sdaOe;
	logic sclPrev, sdaPrev;
	logic rise, fall, start, stop;

	assign rise = sclIn & ~sclPrev;
	assign fall = ~sclIn & sclPrev;
	assign start = sclIn & sclPrev & sdaPrev & ~sdaIn;
	assign stop = sclIn & sclPrev & ~sdaPrev & sdaIn;

	always_comb begin
		next_state = state;
		next_bitCnt = bitCnt;
		next_shiftReg = shiftReg;
		next_regAddr = regAddr;
		next_wrData = wrData;
		next_isRead = isRead;
		next_wrEn = 1'b0;
		next_sdaOe = sdaOe;
		if (start) begin
			next_state = amp_regs_pkg::S_DEV;
			next_bitCnt = 4'h0;
			next_sdaOe = 1'b0;
		end else if (stop) begin
			next_state = amp_regs_pkg::S_IDLE;
			next_sdaOe = 1'b0;
		end else begin
			case (state)
				amp_regs_pkg::S_DEV, amp_regs_pkg::S_PTR, amp_regs_pkg::S_WR: begin
					if (rise && bitCnt < 4'h8) begin
						next_shiftReg = {shiftReg[6:0], sdaIn};
						next_bitCnt = bitCnt + 4'h1;
					end else if (fall && bitCnt == 4'h8) begin
						next_bitCnt = 4'h0;
						next_sdaOe = 1'b1;
						if (state == amp_regs_pkg::S_DEV) begin
							// Only our own address is acknowledged
							if (shiftReg[7:1] == devAddr) begin
								next_state = amp_regs_pkg::S_DEVACK;
								next_isRead = shiftReg[0];
							end else begin
								next_state = amp_regs_pkg::S_IDLE;
								next_sdaOe = 1'b0;
							end
						end else if (state == amp_regs_pkg::S_PTR) begin
							next_regAddr = shiftReg;
							next_state = amp_regs_pkg::S_PTRACK;
						end else begin
							next_wrEn = 1'b1;
							next_wrData = shiftReg;
							next_state = amp_regs_pkg::S_WRACK;
						end
					end
				end
				amp_regs_pkg::S_DEVACK: begin
					if (fall) begin
						if (isRead) begin
							next_state = amp_regs_pkg::S_RD;
							next_shiftReg = rdData;
							next_sdaOe = ~rdData[7];
						end else begin
							next_state = amp_regs_pkg::S_PTR;
							next_sdaOe = 1'b0;
						end
					end
				end
				amp_regs_pkg::S_PTRACK, amp_regs_pkg::S_WRACK: begin
					if (fall) begin
						next_state = amp_regs_pkg::S_WR;
						next_sdaOe = 1'b0;
						if (state == amp_regs_pkg::S_WRACK)
							next_regAddr = regAddr + 8'h01;
					end
				end
				amp_regs_pkg::S_RD: begin
					if (fall) begin
						if (bitCnt == 4'h7) begin
							next_state = amp_regs_pkg::S_RDACK;
							next_sdaOe = 1'b0;
							next_bitCnt = 4'h0;
						end else begin
							next_shiftReg = {shiftReg[6:0], 1'b0};
							next_sdaOe = ~shiftReg[6];
							next_bitCnt = bitCnt + 4'h1;
						end
					end
				end
				amp_regs_pkg::S_RDACK: begin
					// A NACK from the master ends the read
					if (rise) begin
						if (sdaIn)
							next_state = amp_regs_pkg::S_IDLE;
						else
							next_regAddr = regAddr + 8'h01;
					end else if (fall) begin
						next_state = amp_regs_pkg::S_RD;
						next_shiftReg = rdData;
						next_sdaOe = ~rdData[7];
					end
				end
				default: next_state = amp_regs_pkg::S_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state <= amp_regs_pkg::S_IDLE;
			bitCnt <= 4'h0;
			shiftReg <= 8'h00;
			regAddr <= 8'h00;
			wrData <= 8'h00;
			isRead <= 1'b0;
			wrEn <= 1'b0;
			sdaOe <= 1'b0;
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
		end else begin
			state <= next_state;
			bitCnt <= next_bitCnt;
			shiftReg <= next_shiftReg;
			regAddr <= next_regAddr;
			wrData <= next_wrData;
			isRead <= next_isRead;
			wrEn <= next_wrEn;
			sdaOe <= next_sdaOe;
			sclPrev <= sclIn;
			sdaPrev <= sdaIn;
		end
	end
endmodule

// File: sim/amp_clock_mute_volume_regs_tb.sv
module amp_clock_mute_volume_regs_tb;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [7:0] data;
		logic [10:0] ratio;
		logic valid;
	} row_s;
	localparam logic [6:0] ADDR0 = {amp_regs_pkg::DEV_ADDR_BASE, 1'b0};
	localparam logic signed [23:0] ONE = 24'h010000;
	logic [7:0] rstVals [7] = '{8'h00, 8'h01, 8'h10, 8'h18, 8'h18, 8'h18, 8'h00};
	logic sys_clk, rst, scl, sdaPull, sdaOut, sdaOe, faultDrv, faultOut, faultOe, errorIn;
	logic sampleStrobe, bclkEnable, ratioValid, uvThresholdSel, softResetActive, ack;
	logic signed [23:0] leftIn, rightIn, leftOut, rightOut;
	logic [1:0] sampleRateGroup;
	logic [10:0] clkRatio;
	logic [7:0] rd;
	int errCount = 0;
	int nTests = 0;
	// Both lines are open drain; SDA has a pull-up, the released fault pin follows faultDrv
	wire logic sdaLine = ~(sdaPull | (sdaOe & ~sdaOut));
	wire logic faultPin = (faultOe & ~faultOut) ? 1'b0 : faultDrv;
	row_s rows [15] = '{'{8'h80, 11'h400, 1'b1}, '{8'h01, 11'h040, 1'b1}, '{8'h82, 11'h080, 1'b1},
		'{8'h03, 11'h0C0, 1'b1}, '{8'h05, 11'h180, 1'b1}, '{8'h07, 11'h240, 1'b1},
		'{8'h08, 11'h300, 1'b1}, '{8'h09, 11'h400, 1'b1}, '{8'h0A, 11'h000, 1'b0},
		'{8'h10, 11'h200, 1'b1}, '{8'h16, 11'h200, 1'b1}, '{8'h17, 11'h000, 1'b0},
		'{8'h20, 11'h100, 1'b1}, '{8'hB4, 11'h100, 1'b1}, '{8'h35, 11'h000, 1'b0}};
	i2c_host host (.sys_clk(sys_clk), .sdaLine(sdaLine), .scl(scl), .sdaPull(sdaPull));
	amp_clock_mute_volume_regs DUT (.sys_clk(sys_clk), .rst(rst), .sclIn(scl), .sdaIn(sdaLine),
		.sdaOut(sdaOut), .sdaOe(sdaOe), .faultIn(faultPin), .faultOut(faultOut),
		.faultOe(faultOe), .errorIn(errorIn), .sampleStrobe(sampleStrobe), .leftIn(leftIn),
		.rightIn(rightIn), .leftOut(leftOut), .rightOut(rightOut), .bclkEnable(bclkEnable),
		.sampleRateGroup(sampleRateGroup), .clkRatio(clkRatio), .ratioValid(ratioValid),
		.uvThresholdSel(uvThresholdSel), .softResetActive(softResetActive));
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
		nTests++;
		if (seen !== exp) begin
			errCount++;
			$display("FAIL at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic wrapUp();
		$display("Comparisons %0d, mismatches %0d", nTests, errCount);
		if (errCount == 0 && nTests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
		host.writeReg(ADDR0, ptr, {16'h0000, d}, 1, ack);
		check(ack, 1'b1, "write acknowledged");
	endtask
	// Output settles on the clock edge that samples the strobe; three clocks leave margin
	task automatic sample(input int n, input logic signed [23:0] l, input logic signed [23:0] r);
		repeat (n) begin
			@(negedge sys_clk);
			leftIn = l;
			rightIn = r;
			sampleStrobe = 1'b1;
			@(negedge sys_clk);
			sampleStrobe = 1'b0;
			repeat (3) @(negedge sys_clk);
		end
	endtask
	initial begin
		repeat (60000) @(posedge sys_clk);
		errCount++;
		wrapUp();
	end
	initial begin
		rst = 1'b1;
		sampleStrobe = 1'b0;
		leftIn = '0;
		rightIn = '0;
		errorIn = 1'b0;
		faultDrv = 1'b0;
		repeat (8) @(negedge sys_clk);
		rst = 1'b0;
		@(negedge sys_clk);
		check(softResetActive, 1'b0, "no soft reset");
		check(clkRatio, 11'h040, "default ratio");
		// Unmapped writes must leave no trace
		host.writeReg(ADDR0, 8'h06, 24'h0000FF, 1, ack);
		for (int a = 0; a < 7; a++) begin
			host.readReg(ADDR0, 8'(a), rd);
			check(rd, rstVals[a], "reset value");
		end
		foreach (rows[i]) begin
			wr(amp_regs_pkg::REG_CLOCK_RATE, rows[i].data);
			check(bclkEnable, rows[i].data[7], "bit clock enable");
			check(sampleRateGroup, rows[i].data[5:4], "rate group");
			check(clkRatio, rows[i].ratio, "ratio");
			check(ratioValid, rows[i].valid, "ratio valid");
			host.readReg(ADDR0, amp_regs_pkg::REG_CLOCK_RATE, rd);
			check(rd, rows[i].data, "readback");
		end
		errorIn = 1'b1;
		wr(8'h02, 8'h70);
		check(uvThresholdSel, 1'b1, "threshold select");
		check(faultOe, 1'b0, "pin is address input");
		wr(8'h02, 8'hD0);
		check(faultOe, 1'b1, "fault driven");
		check(faultOut, 1'b0, "fault pin pulls low");
		faultDrv = 1'b1;
		errorIn = 1'b0;
		repeat (2) @(negedge sys_clk);
		check(faultOe, 1'b0, "fault released");
		// Address held while in fault mode, so this still reaches the old address
		wr(8'h02, 8'h50);
		host.writeReg(ADDR0, 8'h03, 24'h000018, 1, ack);
		check(ack, 1'b0, "old address refused");
		host.writeReg(ADDR0 | 7'h01, 8'h03, 24'h000018, 1, ack);
		check(ack, 1'b1, "pin selected address");
		faultDrv = 1'b0;
		sample(1, ONE, ONE);
		check(leftOut, 24'h0, "fade starts silent");
		sample(1, ONE, ONE);
		check(leftOut, 24'h000100, "first fade step");
		sample(256, ONE, ONE);
		check(leftOut, ONE, "unity gain");
		wr(8'h03, 8'h00);
		sample(1, ONE, ONE);
		check(leftOut, 24'h040000, "master gain");
		host.writeReg(ADDR0, 8'h04, 24'h0000E7, 2, ack);
		sample(1, ONE, ONE);
		check(leftOut, 24'h100000, "summed gain");
		check(rightOut, 24'h0, "mute code");
		host.readReg(ADDR0, 8'h05, rd);
		check(rd, 8'hE7, "pointer advanced");
		host.writeReg(ADDR0, 8'h03, 24'h181818, 3, ack);
		wr(8'h02, 8'h54);
		sample(1, ONE, ONE);
		check(leftOut, ONE, "mute not abrupt");
		sample(257, ONE, ONE);
		check(leftOut, 24'h0, "left muted");
		check(rightOut, ONE, "right unaffected");
		wr(8'h02, 8'h58);
		sample(258, ONE, ONE);
		check(leftOut, 24'h0, "master mutes left");
		check(rightOut, 24'h0, "master mutes right");
		wr(8'h02, 8'h51);
		sample(258, ONE, ONE);
		check(leftOut, ONE, "steady input through compensation");
		sample(1, 24'h020000, 24'h020000);
		check(leftOut, 24'h01C000, "compensation step");
		wr(8'h02, 8'h10);
		sample(40, ONE, ONE);
		check(leftOut < ONE, 1'b1, "constant level decays");
		wr(8'h02, 8'h50);
		sample(2, ONE, ONE);
		check(leftOut, ONE, "blocker bypassed");
		wr(8'h02, 8'h40);
		check(softResetActive, 1'b1, "soft reset");
		check(leftOut, 24'h0, "audio cleared");
		host.readReg(ADDR0, 8'h03, rd);
		check(rd, 8'h18, "registers kept");
		wrapUp();
	end
endmodule

// File: sim/i2c_host.sv
module i2c_host (
	input wire logic sys_clk,
	input wire logic sdaLine,
	output logic scl,
	output logic sdaPull
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		scl = 1'b1;
		sdaPull = 1'b0;
	end
	// Four system clocks per SCL phase keeps above the slave's three-cycle minimum
	task automatic phase();
		repeat (4) @(negedge sys_clk);
	endtask
	task automatic start();
		sdaPull = 1'b0;
		phase();
		scl = 1'b1;
		phase();
		sdaPull = 1'b1;
		phase();
		scl = 1'b0;
	endtask
	task automatic stop();
		sdaPull = 1'b1;
		phase();
		scl = 1'b1;
		phase();
		sdaPull = 1'b0;
		phase();
	endtask
	// Sampled at the end of the high phase, before SCL falls
	task automatic clockBit(input logic b, output logic seen);
		sdaPull = ~b;
		phase();
		scl = 1'b1;
		phase();
		seen = sdaLine;
		scl = 1'b0;
	endtask
	task automatic xfer(input logic [7:0] txd, input logic ackBit, output logic [7:0] rxd,
		output logic ack);
		for (int i = 7; i >= 0; i--) begin
			clockBit(txd[i], rxd[i]);
		end
		clockBit(ackBit, ack);
		ack = ~ack;
	endtask
	task automatic writeReg(input logic [6:0] dev, input logic [7:0] ptr,
		input logic [23:0] data, input int n, output logic ack);
		logic [7:0] junk;
		logic a;
		start();
		xfer({dev, 1'b0}, 1'b1, junk, ack);
		xfer(ptr, 1'b1, junk, a);
		ack &= a;
		for (int i = n; i > 0; i--) begin
			xfer(data[8*i-1 -: 8], 1'b1, junk, a);
			ack &= a;
		end
		stop();
	endtask
	task automatic readReg(input logic [6:0] dev, input logic [7:0] ptr, output logic [7:0] val);
		logic [7:0] junk;
		logic a;
		start();
		xfer({dev, 1'b0}, 1'b1, junk, a);
		xfer(ptr, 1'b1, junk, a);
		start();
		xfer({dev, 1'b1}, 1'b1, junk, a);
		// Released ninth bit is a NACK, which ends the read
		xfer(8'hFF, 1'b1, val, a);
		stop();
	endtask
endmodule
